// ==== src/flash_status_defs.vh ====
// Functional notes
// - latch-set command completion sets write latch
// - writes need latch set; rejected otherwise
// - latch-clear command completion clears write latch
// - latch cleared at power-up and write completions
// - status read accepted anytime, returns current byte
// - status byte repeats while select stays low
// - status layout lock,0,0,0,size hi/lo,latch,busy
// - latch and busy bits are read-only
// - busy reads 1 during self-timed cycles
// - size bits refuse program/erase in region
// - full wipe only when both size bits zero
// - lock and low pin give hard lock
// - status write keeps b6-b4,b1,b0; b6-b4 zero
// - status write needs rise after eighth data bit
// - valid status write starts timed busy cycle
// - lock clear: writes allowed when latch set
// - lock set, pin high: writes need latch
// - hard lock entered in either event order
// - only raising pin or reset leaves hard lock
// - opcodes 06,04,05,01 decoded as one byte
// - size 00 none,01 top,10 half,11 all
// - writes need select rise on byte boundary
// - input shifted MSB first on rising clock
`ifndef FLASH_STATUS_DEFS_VH
`define FLASH_STATUS_DEFS_VH
// command codes
`define OPC_LATCH_SET 8'h06
`define OPC_LATCH_CLEAR 8'h04
`define OPC_STATUS_READ 8'h05
`define OPC_STATUS_WRITE 8'h01
`define OPC_PAGE_PROG 8'h02
`define OPC_REGION_WIPE 8'hD8
`define OPC_FULL_WIPE 8'hC7
// status byte fields
`define STAT_LOCK 7
`define STAT_SIZE_HI 3
`define STAT_SIZE_LO 2
`define STAT_LATCH 1
`define STAT_BUSY 0
`define STAT_ZERO_BITS 3'h0
// reset values
`define RST_LOCK 1'h0
`define RST_SIZE 2'h0
`define RST_LATCH 1'h0
// protect size codes and sector field
`define SIZE_NONE 2'h0
`define SIZE_TOP 2'h1
`define SIZE_HALF 2'h2
`define SIZE_ALL 2'h3
`define SECTOR_TOP 2'h3
`define SECTOR_MSB 16
`define SECTOR_LSB 15
// byte counts at a valid end of sequence
`define BYTES_CMD 3'h1
`define BYTES_STATUS_WRITE_CMD 3'h2
`define BYTES_WIPE 3'h4
`define BYTES_PROG 3'h5
`define BYTES_MAX 3'h7
`define ADDR_FIRST 3'h1
`define ADDR_LAST 3'h3
`define BIT_BOUNDARY 3'h0
`define BIT_LAST 3'h7
// operation kinds passed to the array
`define OP_STATUS 2'h0
`define OP_PROG 2'h1
`define OP_REGION 2'h2
`define OP_FULL 2'h3
// self-timed cycle lengths in core clock cycles
`define CYC_WRITE 16'h0FA0
`define CYC_PROG 16'h0BB8
`define CYC_REGION 16'h0FA0
`define CYC_FULL 16'h0FA0
`define CYC_ONE 16'h0001
`define CYC_ZERO 16'h0000
`endif

// ==== src/fs_sync2.v ====
`timescale 1ns/1ps
module fs_sync2 #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  // data
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta_q[g] <= RST_VAL[g];
          sync_q[g] <= RST_VAL[g];
        end else if (i_ce) begin
          meta_q[g] <= i_async[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate
  assign o_sync = sync_q;
endmodule // fs_sync2

// ==== src/fs_cycle_timer.v ====
`timescale 1ns/1ps
`include "flash_status_defs.vh"
module fs_cycle_timer (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  // control
  input wire i_start,
  input wire [15:0] i_len,
  output wire o_busy,
  output wire o_done
);
  reg [15:0] cnt_q;
  reg busy_q;
  reg done_q;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= `CYC_ZERO;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (i_ce) begin
      done_q <= 1'b0;
      if (i_start && !busy_q) begin
        cnt_q <= i_len;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q <= `CYC_ONE) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          cnt_q <= `CYC_ZERO;
        end else begin
          cnt_q <= cnt_q - `CYC_ONE;
        end
      end
    end
  end
  assign o_busy = busy_q;
  assign o_done = done_q;
endmodule // fs_cycle_timer

// ==== src/flash_status_protect.v ====
`timescale 1ns/1ps
`include "flash_status_defs.vh"
module flash_status_protect (
  // core clock, enable and reset
  input wire i_core_clk,
  input wire i_ce,
  input wire i_rst_n,
  // serial pins
  input wire i_sclk,
  input wire i_cs_n,
  input wire i_mosi,
  input wire i_wp_n,
  output reg o_miso,
  output reg o_miso_oe_n,
  // status view
  output reg [7:0] o_status,
  output reg o_hard_lock,
  // array operation request
  output reg o_op_start,
  output reg [1:0] o_op_kind,
  output reg [23:0] o_op_addr
);

  ////////////////////////////////////////////////////////////////////////
  // states of the serial frame
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_OPCODE = 2'h1;
  localparam [1:0] ST_BODY = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // reset release
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n_s;

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n_s = rst_sync_q;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  wire [3:0] pins_sync;
  wire sclk_s;
  wire cs_n_s;
  wire mosi_s;
  wire wp_n_s;

  fs_sync2 #(
    .WIDTH(4),
    .RST_VAL(4'hA)
  ) u_pin_sync (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n_s),
    .i_ce(i_ce),
    .i_async({i_cs_n, i_sclk, i_wp_n, i_mosi}),
    .o_sync(pins_sync)
  );

  assign cs_n_s = pins_sync[3];
  assign sclk_s = pins_sync[2];
  assign wp_n_s = pins_sync[1];
  assign mosi_s = pins_sync[0];

  ////////////////////////////////////////////////////////////////////////
  // edge detection
  reg sclk_prev_q;
  reg cs_n_prev_q;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_rise;

  always @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      sclk_prev_q <= 1'b0;
      cs_n_prev_q <= 1'b1;
    end else if (i_ce) begin
      sclk_prev_q <= sclk_s;
      cs_n_prev_q <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_n_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // status register bits
  reg lock_q;
  reg [1:0] size_q;
  reg latch_q;
  wire busy;
  wire hard_lock;
  wire [7:0] status_byte;

  assign hard_lock = lock_q & ~wp_n_s;

  assign status_byte = {lock_q, `STAT_ZERO_BITS, size_q, latch_q,
                        busy};

  ////////////////////////////////////////////////////////////////////////
  // serial input framing
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [2:0] bit_cnt_q;
  reg [2:0] byte_cnt_q;
  reg [7:0] in_sh_q;
  reg [7:0] opcode_q;
  reg [23:0] addr_q;
  wire bit_last;
  wire byte_done;

  assign bit_last = (bit_cnt_q == `BIT_LAST);
  assign byte_done = sclk_rise && bit_last;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (!cs_n_s) begin
          state_d = ST_OPCODE;
        end
      end
      ST_OPCODE: begin
        if (cs_n_s) begin
          state_d = ST_IDLE;
        end else if (byte_done) begin
          state_d = ST_BODY;
        end
      end
      ST_BODY: begin
        if (cs_n_s) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= `BIT_BOUNDARY;
      byte_cnt_q <= 3'h0;
      in_sh_q <= 8'h00;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
    end else if (i_ce) begin
      state_q <= state_d;
      if (state_q == ST_IDLE) begin
        bit_cnt_q <= `BIT_BOUNDARY;
        byte_cnt_q <= 3'h0;
      end else if (sclk_rise) begin
        in_sh_q <= {in_sh_q[6:0], mosi_s};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (byte_done && byte_cnt_q != `BYTES_MAX) begin
          byte_cnt_q <= byte_cnt_q + 3'h1;
        end
        if (state_q == ST_OPCODE && byte_done) begin
          opcode_q <= {in_sh_q[6:0], mosi_s};
        end
        if (byte_cnt_q >= `ADDR_FIRST && byte_cnt_q <= `ADDR_LAST) begin
          addr_q <= {addr_q[22:0], mosi_s};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // end-of-frame decode
  wire on_boundary;
  wire is_latch_set;
  wire is_latch_clear;
  wire is_status_write;
  wire is_page_prog;
  wire is_region_wipe;
  wire is_full_wipe;
  wire [1:0] sector;
  reg region_guarded;

  assign on_boundary = (bit_cnt_q == `BIT_BOUNDARY);

  assign is_latch_set = (opcode_q == `OPC_LATCH_SET) &&
                        (byte_cnt_q == `BYTES_CMD) && on_boundary;
  assign is_latch_clear = (opcode_q == `OPC_LATCH_CLEAR) &&
                          (byte_cnt_q == `BYTES_CMD) && on_boundary;
  assign is_status_write = (opcode_q == `OPC_STATUS_WRITE) &&
                           (byte_cnt_q == `BYTES_STATUS_WRITE_CMD) &&
                           on_boundary;
  assign is_page_prog = (opcode_q == `OPC_PAGE_PROG) &&
                        (byte_cnt_q >= `BYTES_PROG) && on_boundary;
  assign is_region_wipe = (opcode_q == `OPC_REGION_WIPE) &&
                          (byte_cnt_q == `BYTES_WIPE) && on_boundary;
  assign is_full_wipe = (opcode_q == `OPC_FULL_WIPE) &&
                        (byte_cnt_q == `BYTES_CMD) && on_boundary;

  assign sector = addr_q[`SECTOR_MSB:`SECTOR_LSB];

  always @* begin
    case (size_q)
      `SIZE_NONE: region_guarded = 1'b0;
      `SIZE_TOP: region_guarded = (sector == `SECTOR_TOP);
      `SIZE_HALF: region_guarded = sector[1];
      `SIZE_ALL: region_guarded = 1'b1;
      default: region_guarded = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // self-timed cycle
  reg cyc_start;
  reg [15:0] cyc_len;
  reg [1:0] cyc_kind;
  wire cyc_done;
  wire frame_end;
  wire status_wr_ok;

  assign frame_end = cs_rise && (state_q == ST_BODY) && !busy;

  assign status_wr_ok = is_status_write && !hard_lock;

  always @* begin
    cyc_start = 1'b0;
    cyc_len = `CYC_WRITE;
    cyc_kind = `OP_STATUS;
    if (frame_end && latch_q) begin
      if (status_wr_ok) begin
        cyc_start = 1'b1;
      end else if (is_page_prog && !region_guarded) begin
        cyc_start = 1'b1;
        cyc_len = `CYC_PROG;
        cyc_kind = `OP_PROG;
      end else if (is_region_wipe && !region_guarded) begin
        cyc_start = 1'b1;
        cyc_len = `CYC_REGION;
        cyc_kind = `OP_REGION;
      end else if (is_full_wipe && size_q == `SIZE_NONE) begin
        cyc_start = 1'b1;
        cyc_len = `CYC_FULL;
        cyc_kind = `OP_FULL;
      end
    end
  end

  fs_cycle_timer u_timer (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n_s),
    .i_ce(i_ce),
    .i_start(cyc_start),
    .i_len(cyc_len),
    .o_busy(busy),
    .o_done(cyc_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // status register update
  wire new_lock;
  wire [1:0] new_size;

  assign new_lock = in_sh_q[`STAT_LOCK];
  assign new_size = in_sh_q[`STAT_SIZE_HI:`STAT_SIZE_LO];

  always @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      lock_q <= `RST_LOCK;
      size_q <= `RST_SIZE;
      latch_q <= `RST_LATCH;
    end else if (i_ce) begin
      if (cyc_start) begin
        latch_q <= 1'b0;
        if (cyc_kind == `OP_STATUS) begin
          lock_q <= new_lock;
          size_q <= new_size;
        end
      end else if (frame_end && is_latch_set) begin
        latch_q <= 1'b1;
      end else if (frame_end && is_latch_clear) begin
        latch_q <= 1'b0;
      end else if (cyc_done) begin
        // cleared again on completion, a set in that cycle wins
        latch_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status output shifter
  reg [7:0] out_sh_q;
  wire reading;

  assign reading = (state_q == ST_BODY) &&
                   (opcode_q == `OPC_STATUS_READ);

  always @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      out_sh_q <= 8'h00;
      o_miso <= 1'b0;
      o_miso_oe_n <= 1'b1;
    end else if (i_ce) begin
      if (cs_n_s) begin
        o_miso_oe_n <= 1'b1;
      end else if (reading && sclk_fall) begin
        o_miso_oe_n <= 1'b0;
        if (bit_cnt_q == `BIT_BOUNDARY) begin
          o_miso <= status_byte[7];
          out_sh_q <= {status_byte[6:0], 1'b0};
        end else begin
          o_miso <= out_sh_q[7];
          out_sh_q <= {out_sh_q[6:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      o_status <= 8'h00;
      o_hard_lock <= 1'b0;
      o_op_start <= 1'b0;
      o_op_kind <= `OP_STATUS;
      o_op_addr <= 24'h000000;
    end else if (i_ce) begin
      o_status <= status_byte;
      o_hard_lock <= hard_lock;
      o_op_start <= cyc_start && (cyc_kind != `OP_STATUS);
      if (cyc_start) begin
        o_op_kind <= cyc_kind;
        o_op_addr <= addr_q;
      end
    end
  end

endmodule // flash_status_protect

// ==== bench/flash_status_protect_sva.sv ====
`timescale 1ns/1ps
module flash_status_protect_sva (
  // clock and reset
  input wire i_core_clk,
  input wire i_ce,
  input wire i_rst_n,
  // serial pins
  input wire i_sclk,
  input wire i_cs_n,
  input wire i_mosi,
  input wire i_wp_n,
  input wire o_miso,
  input wire o_miso_oe_n,
  // status and array requests
  input wire [7:0] o_status,
  input wire o_hard_lock,
  input wire o_op_start,
  input wire [1:0] o_op_kind,
  input wire [23:0] o_op_addr
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic [15:0] busy_cnt_q;
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) busy_cnt_q <= 16'h0000;
    else busy_cnt_q <= o_status[0] ? busy_cnt_q + 16'h0001 : 16'h0000;
  end
  //////////////////////////////////////////////////////////////////////
  property p_zero_bits; o_status[6:4] == 3'h0; endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("status bits 6 to 4 not zero");
  property p_oe_idle; i_cs_n [*6] |-> o_miso_oe_n; endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("output driven while deselected");
  property p_miso_hold;
    $rose(i_sclk) && !o_miso_oe_n |=> $stable(o_miso) [*6];
  endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("output moved after rising clock");
  property p_hl_enter; (o_status[7] && !i_wp_n) [*6] |-> o_hard_lock;
  endproperty
  a_hl_enter: assert property (p_hl_enter)
    else $error("hard lock not entered");
  property p_hl_exit; i_wp_n [*6] |-> !o_hard_lock; endproperty
  a_hl_exit: assert property (p_hl_exit)
    else $error("hard lock held with pin high");
  property p_busy_latch; $rose(o_status[0]) |-> ##[0:2] !o_status[1];
  endproperty
  a_busy_latch: assert property (p_busy_latch)
    else $error("latch not cleared by timed cycle");
  property p_busy_len; $fell(o_status[0]) |-> busy_cnt_q >= 16'h0BB7;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy cycle too short");
  property p_busy_max; busy_cnt_q <= 16'h0FA2; endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy cycle too long");
  property p_op_busy; o_op_start |-> ##[0:3] o_status[0]; endproperty
  a_op_busy: assert property (p_op_busy)
    else $error("accepted op without busy");
  property p_op_size; o_op_start |-> o_status[3:2] != 2'h3; endproperty
  a_op_size: assert property (p_op_size)
    else $error("op accepted with all sectors guarded");
  property p_full_wipe;
    o_op_start && o_op_kind == 2'h3 |-> o_status[3:2] == 2'h0;
  endproperty
  a_full_wipe: assert property (p_full_wipe)
    else $error("full wipe with guard set");
endmodule // flash_status_protect_sva
bind flash_status_protect flash_status_protect_sva chk (
  .i_core_clk(i_core_clk), .i_ce(i_ce), .i_rst_n(i_rst_n),
  .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_mosi(i_mosi), .i_wp_n(i_wp_n),
  .o_miso(o_miso), .o_miso_oe_n(o_miso_oe_n), .o_status(o_status),
  .o_hard_lock(o_hard_lock), .o_op_start(o_op_start),
  .o_op_kind(o_op_kind), .o_op_addr(o_op_addr)
);

// ==== bench/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model (
  // clock
  input wire i_clk,
  // serial pins
  input wire i_miso,
  input wire i_miso_oe_n,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // released output reads back inverted, so a missing drive shows
  wire miso_seen;
  assign miso_seen = i_miso_oe_n ? ~i_miso : i_miso;
  // one frame: n bits out msb first, then nrd bits in, 8-cycle clock
  task automatic frame(input logic [39:0] tx, input int n, input int nrd,
                       output logic [23:0] rx);
    int i;
    rx = 24'h000000;
    @(posedge i_clk) o_cs_n <= 1'b0;
    for (i = 0; i < n + nrd; i++) begin
      @(posedge i_clk);
      o_sclk <= 1'b0;
      o_mosi <= (i < n) ? tx[n-1-i] : ~o_mosi;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      if (i >= n) rx = {rx[22:0], miso_seen};
      repeat (3) @(posedge i_clk);
    end
    @(posedge i_clk) o_sclk <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi;
    repeat (20) @(posedge i_clk);
  endtask
endmodule // spi_host_model

// ==== bench/tb_spi_flash_status_protect.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_spi_flash_status_protect;
  typedef struct {
    logic [39:0] tx; int n; logic wp;
    logic [7:0] exp; logic [7:0] msk; logic hl; int ops;
  } row_t;
  logic core_clk, rst_n, ce, wp_n, sclk, cs_n, mosi;
  wire miso, miso_oe_n, hard_lock, op_start;
  wire [7:0] status;
  wire [1:0] op_kind;
  wire [23:0] op_addr;
  logic [23:0] rd;
  int n_errors = 0;
  int n_tests = 0;
  int n_ops = 0;
  row_t rows [25] = '{
    '{40'h06, 8, 1, 8'h02, 8'hFF, 0, 0}, '{40'h04, 8, 1, 8'h00, 8'hFF, 0, 0},
    '{40'h018C, 16, 1, 8'h00, 8'hFF, 0, 0}, '{40'h06, 8, 1, 8'h02, 8'hFF, 0, 0},
    '{40'h0319, 17, 1, 8'h00, 8'hFD, 0, 0}, '{40'h06, 8, 1, 8'h02, 8'hFF, 0, 0},
    '{40'h01FF, 16, 1, 8'h8C, 8'hFF, 0, 0}, '{40'h06, 8, 0, 8'h8E, 8'hFF, 1, 0},
    '{40'h0100, 16, 0, 8'h8C, 8'hFD, 1, 0}, '{40'h04, 8, 0, 8'h8C, 8'hFF, 1, 0},
    '{40'h06, 8, 1, 8'h8E, 8'hFF, 0, 0}, '{40'h0180, 16, 1, 8'h80, 8'hFF, 0, 0},
    '{40'h06, 8, 1, 8'h82, 8'hFF, 0, 0}, '{40'hC7, 8, 1, 8'h80, 8'hFF, 0, 1},
    '{40'h06, 8, 1, 8'h82, 8'hFF, 0, 1}, '{40'h0184, 16, 1, 8'h84, 8'hFF, 0, 1},
    '{40'h06, 8, 1, 8'h86, 8'hFF, 0, 1},
    '{40'h02018000AA, 40, 1, 8'h84, 8'hFD, 0, 1},
    '{40'h04, 8, 1, 8'h84, 8'hFF, 0, 1}, '{40'h06, 8, 1, 8'h86, 8'hFF, 0, 1},
    '{40'h0200000055, 40, 1, 8'h84, 8'hFF, 0, 2},
    '{40'h06, 8, 1, 8'h86, 8'hFF, 0, 2}, '{40'hC7, 8, 1, 8'h84, 8'hFD, 0, 2},
    '{40'h06, 8, 1, 8'h86, 8'hFF, 0, 2}, '{40'hD8000000, 32, 1, 8'h84, 8'hFF, 0, 3}
  };
  spi_host_model host (.i_clk(core_clk), .i_miso(miso),
    .i_miso_oe_n(miso_oe_n), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
  flash_status_protect dut (.i_core_clk(core_clk), .i_ce(ce),
    .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
    .i_wp_n(wp_n), .o_miso(miso), .o_miso_oe_n(miso_oe_n),
    .o_status(status), .o_hard_lock(hard_lock), .o_op_start(op_start),
    .o_op_kind(op_kind), .o_op_addr(op_addr));
  //////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (op_start === 1'b1) n_ops++;
  end
  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // poll busy before the next command
  task automatic wait_idle();
    int i;
    repeat (8) @(posedge core_clk);
    for (i = 0; i < 5000 && status[0] !== 1'b0; i++) @(posedge core_clk);
    `CHK(status[0], 1'b0);
  endtask
  task automatic read_status(input int nrd);
    host.frame(40'h05, 8, nrd, rd);
  endtask
  initial begin
    repeat (90000) @(posedge core_clk);
    n_errors++;
    stop_test();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wp_n = 1'b1;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    `CHK(status, 8'h00);
    `CHK(miso_oe_n, 1'b1);
    foreach (rows[k]) begin
      wp_n <= rows[k].wp;
      repeat (8) @(posedge core_clk);
      host.frame(rows[k].tx, rows[k].n, 0, rd);
      wait_idle();
      read_status(8);
      `CHK(rd[7:0] & rows[k].msk, rows[k].exp & rows[k].msk);
      `CHK(status & rows[k].msk, rows[k].exp & rows[k].msk);
      `CHK(hard_lock, rows[k].hl);
      `CHK(n_ops, rows[k].ops);
    end
    `CHK(op_kind, 2'h2);
    `CHK(op_addr, 24'h000000);
    // read while a status write runs, then a command during busy
    host.frame(40'h06, 8, 0, rd);
    host.frame(40'h0184, 16, 0, rd);
    read_status(8);
    `CHK(rd[7:0], 8'h85);
    host.frame(40'h06, 8, 0, rd);
    wait_idle();
    read_status(24);
    `CHK(rd, 24'h848484);
    `CHK(miso_oe_n, 1'b1);
    // reset in mid-run
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK(status, 8'h00);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHK(status, 8'h00);
    `CHK(miso_oe_n, 1'b1);
    `CHK(hard_lock, 1'b0);
    repeat (8) @(posedge core_clk);
    host.frame(40'h06, 8, 0, rd);
    read_status(8);
    `CHK(rd[7:0], 8'h02);
    stop_test();
  end
endmodule // tb_spi_flash_status_protect
